//--- logic/compare_and_pwm_unit.v
// compare and standard pwm unit with its compare and period timers
//
// Overview of operation
// - clearing mode control forces the compare output latch low
// - mode 1010 sets the flag only, pin untouched
// - mode 1011 resets compare timer and starts conversion if enabled
// - trigger is immediate; timer clears on the next timer tick
// - trigger-caused timer reset never sets the timer overflow flag
// - changing compare value before the clear edge cancels the clear
// - pwm mode makes up to 10-bit duty output on the pin
// - clearing mode control releases the pin to port function
// - period is (limit+1) times 4 clocks times prescale
// - after timer equals limit: clear timer, set pin if new duty is nonzero, load duty
// - postscaler does not affect pwm period
// - duty is low-byte register plus two low control bits
// - in pwm mode active duty high byte is read only
// - duty double buffered, takes effect at period boundary
// - time base is period timer plus phase or prescaler bits
// - time base equal to active duty drives pin low
// - pulse wider than period leaves the pin unchanged
// - resolution is log2 of 4 times (limit+1)
// - sleep freezes timer and state, pin holds its level
// - any reset restores registers and makes pin an input
// - compare pair continuously compared with compare timer
// - 1000 sets, 1001 clears output with flag; 11xx is pwm
// - every compare mode sets the irq flag on match
// - mode 0000 switches unit off and resets its state
`timescale 1ns/1ns
`default_nettype none
`include "compare_pwm_consts.vh"
module compare_and_pwm_unit (
    input wire ref_clk,
    input wire nrst,
    input wire [3:0] mode_select_field,
    input wire [1:0] duty_low_bits,
    input wire [7:0] duty_or_compare_low_byte,
    input wire [7:0] compare_high_byte,
    input wire [7:0] period_limit,
    input wire [1:0] period_timer_prescale,
    input wire period_timer_run,
    input wire compare_timer_run,
    input wire compare_timer_ext_clk,
    input wire compare_timer_ext_mode,
    input wire converter_enabled,
    input wire sleep,
    input wire pin_direction_bit,
    input wire port_data_latch,
    input wire irq_flag_clear,
    input wire overflow_flag_clear,
    input wire period_flag_clear,
    output reg unit_output_pin,
    output reg unit_output_pin_oe,
    output reg unit_irq_flag,
    output reg timer_overflow_flag,
    output reg period_timer_match_flag,
    output reg conversion_start,
    output reg [7:0] active_duty_high_byte,
    output reg [7:0] period_timer,
    output reg [15:0] compare_timer
);
    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    function is_pwm;
        input [3:0] m;
        is_pwm = (m[3:2] == `MODE_PWM_HI);
    endfunction

    function is_compare;
        input [3:0] m;
        is_compare = (m[3:2] == 2'b10);
    endfunction

    localparam ST_OFF = 3'b001;
    localparam ST_CMP = 3'b010;
    localparam ST_PWM = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg cmp_latch;
    reg trig_pending;
    reg [1:0] duty_low_latch;
    reg pwm_level;
    reg ext_clk_prev;
    wire ext_clk_s;
    wire tick;
    wire [1:0] fine_bits;
    wire run_active;
    wire cmp_tick;
    wire [15:0] compare_value;
    wire cmp_match;
    wire [9:0] time_base;
    wire [9:0] active_duty;
    wire period_end;
    wire mode_pwm;
    wire mode_cmp;
    wire trig_hit;
    wire timer_clear;

    assign mode_pwm = is_pwm(mode_select_field);
    assign mode_cmp = is_compare(mode_select_field);

    // ----------------------------------------
    // input synchronisation and period tick
    // ----------------------------------------
    // external compare timer clock only usable as synchronised counter
    sync2 u_ext_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .d(compare_timer_ext_clk),
        .q(ext_clk_s)
    );

    assign run_active = period_timer_run && !sleep;

    period_prescaler u_presc (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(run_active),
        .period_timer_prescale(period_timer_prescale),
        .tick(tick),
        .fine_bits(fine_bits)
    );

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always @* begin
        case (1'b1)
            mode_pwm: next_state = ST_PWM;
            mode_cmp: next_state = ST_CMP;
            default: next_state = ST_OFF;
        endcase
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_OFF;
        end else if (!sleep) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // compare timer and match
    // ----------------------------------------
    assign cmp_tick = compare_timer_run && !sleep &&
                      (compare_timer_ext_mode ? (ext_clk_s && !ext_clk_prev) : 1'b1);
    assign compare_value = {compare_high_byte, duty_or_compare_low_byte};
    // match holds every cycle the timer equals the value, except while a trigger clear is pending
    assign cmp_match = mode_cmp && (compare_timer == compare_value) && !trig_pending;
    assign trig_hit = cmp_match && state == ST_CMP && mode_select_field == `MODE_CMP_TRIG;
    // the clear waits for the timer edge; a changed value cancels it
    assign timer_clear = cmp_tick && (trig_pending || trig_hit) &&
                         (compare_timer == compare_value);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            compare_timer <= 16'h0000;
            ext_clk_prev <= 1'b0;
            trig_pending <= 1'b0;
            timer_overflow_flag <= 1'b0;
        end else begin
            ext_clk_prev <= ext_clk_s;
            if (timer_clear) begin
                compare_timer <= 16'h0000;
            end else if (cmp_tick) begin
                compare_timer <= compare_timer + 16'h0001;
            end
            // re-match suppressed until the next timer edge
            if (cmp_tick) begin
                trig_pending <= 1'b0;
            end else if (trig_hit) begin
                trig_pending <= 1'b1;
            end
            // overflow flag only from natural roll-over, set beats clear
            if (cmp_tick && !timer_clear && compare_timer == 16'hffff) begin
                timer_overflow_flag <= 1'b1;
            end else if (overflow_flag_clear) begin
                timer_overflow_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // compare actions, flag and trigger pulse
    // ----------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmp_latch <= 1'b0;
            unit_irq_flag <= 1'b0;
            conversion_start <= 1'b0;
        end else begin
            conversion_start <= 1'b0;
            if (mode_select_field == `MODE_OFF) begin
                cmp_latch <= 1'b0;
            end else if (cmp_match && state == ST_CMP && !sleep) begin
                case (mode_select_field)
                    `MODE_CMP_SET: cmp_latch <= 1'b1;
                    `MODE_CMP_CLR: cmp_latch <= 1'b0;
                    `MODE_CMP_TRIG: conversion_start <= converter_enabled;
                    default: cmp_latch <= cmp_latch;
                endcase
            end
            if (cmp_match && state == ST_CMP && !sleep) begin
                unit_irq_flag <= 1'b1;
            end else if (irq_flag_clear) begin
                unit_irq_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pwm period timer and duty buffers
    // ----------------------------------------
    assign time_base = {period_timer, fine_bits};
    assign active_duty = {active_duty_high_byte, duty_low_latch};
    assign period_end = tick && (period_timer == period_limit);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            period_timer <= 8'h00;
            period_timer_match_flag <= 1'b0;
            active_duty_high_byte <= 8'h00;
            duty_low_latch <= 2'h0;
            pwm_level <= 1'b0;
        end else begin
            if (period_end) begin
                period_timer <= 8'h00;
            end else if (tick) begin
                period_timer <= period_timer + 8'h01;
            end
            if (period_end) begin
                period_timer_match_flag <= 1'b1;
            end else if (period_flag_clear) begin
                period_timer_match_flag <= 1'b0;
            end
            if (state != ST_PWM) begin
                // compare modes expose the written high byte here
                active_duty_high_byte <= compare_high_byte;
                pwm_level <= 1'b0;
            end else if (period_end) begin
                // read only in pwm, reloaded only here
                active_duty_high_byte <= duty_or_compare_low_byte;
                duty_low_latch <= duty_low_bits;
                pwm_level <= ({duty_or_compare_low_byte, duty_low_bits} != 10'h000);
            end else if (run_active && time_base == active_duty) begin
                // duty beyond the period never matches, level stays
                pwm_level <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            unit_output_pin <= 1'b0;
            unit_output_pin_oe <= 1'b0;
        end else if (!sleep) begin
            unit_output_pin_oe <= !pin_direction_bit;
            case (next_state)
                // mask the match cycle so the pulse lasts exactly duty time-base steps
                ST_PWM: unit_output_pin <= pwm_level && (time_base != active_duty);
                ST_CMP: unit_output_pin <= (mode_select_field[3:1] == 3'b100) ?
                                           cmp_latch : port_data_latch;
                default: unit_output_pin <= port_data_latch;
            endcase
        end
    end
endmodule // compare_and_pwm_unit
`default_nettype wire

//--- logic/compare_pwm_consts.vh
// constants shared by the compare and pwm unit
`ifndef COMPARE_PWM_CONSTS_VH
`define COMPARE_PWM_CONSTS_VH

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MODE_OFF 4'h0
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_TRIG 4'hb
`define MODE_PWM_HI 2'h3

// ----------------------------------------
// prescale codes and widths
// ----------------------------------------
`define PRESCALE_1 2'h0
`define PRESCALE_4 2'h1
`define CYCLES_PER_TICK 2'h3
`define PERIOD_RESET 8'hff

`endif

//--- logic/period_prescaler.v
// period timer tick generator: 4 system phases times prescale
`timescale 1ns/1ns
`default_nettype none
`include "compare_pwm_consts.vh"
module period_prescaler (
    input wire ref_clk,
    input wire nrst,
    input wire run,
    input wire [1:0] period_timer_prescale,
    output wire tick,
    output wire [1:0] fine_bits
);
    reg [5:0] count;
    wire [5:0] last;

    // 1:1 -> 3, 1:4 -> 15, else 1:16 -> 63
    assign last = (period_timer_prescale == `PRESCALE_1) ? 6'h03 :
                  (period_timer_prescale == `PRESCALE_4) ? 6'h0f : 6'h3f;
    assign tick = run && (count == last);
    // low two bits of time base: clock phase at 1:1, prescaler bits otherwise
    assign fine_bits = (period_timer_prescale == `PRESCALE_1) ? count[1:0] :
                       (period_timer_prescale == `PRESCALE_4) ? count[3:2] : count[5:4];

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count <= 6'h00;
        end else if (run) begin
            count <= (count >= last) ? 6'h00 : count + 6'h01;
        end
    end
endmodule // period_prescaler
`default_nettype wire

//--- logic/sync2.v
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync2 (
    input wire ref_clk,
    input wire nrst,
    input wire d,
    output reg q
);
    reg meta;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync2
`default_nettype wire

//--- testbench/compare_and_pwm_unit_assertions.sv
// concurrent checks on the compare and pwm unit ports
`timescale 1ns/1ns
`default_nettype none
module compare_and_pwm_unit_assertions (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] mode_select_field,
    input wire logic [7:0] duty_or_compare_low_byte,
    input wire logic [7:0] compare_high_byte,
    input wire logic sleep,
    input wire logic irq_flag_clear,
    input wire logic unit_output_pin,
    input wire logic unit_irq_flag,
    input wire logic timer_overflow_flag,
    input wire logic conversion_start,
    input wire logic [7:0] active_duty_high_byte,
    input wire logic [7:0] period_limit,
    input wire logic [7:0] period_timer,
    input wire logic [15:0] compare_timer
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire [3:0] m = mode_select_field;
    wire hit = m[3:2] == 2'h2 && !sleep
        && compare_timer == {compare_high_byte, duty_or_compare_low_byte};
    property p_irq_set; hit && m == $past(m) |=> unit_irq_flag; endproperty
    a_irq_set: assert property (p_irq_set) else $error("no flag on match");
    property p_irq_hold; unit_irq_flag && !irq_flag_clear |=> unit_irq_flag; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
    property p_pin_set; hit && m == 4'h8 && $past(m) == m |-> ##[1:2] unit_output_pin;
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin not set");
    property p_pin_clr; hit && m == 4'h9 && $past(m) == m |-> ##[1:2] !unit_output_pin;
    endproperty
    a_pin_clr: assert property (p_pin_clr) else $error("pin not cleared");
    property p_start_pulse; conversion_start |=> !conversion_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    property p_trig_clear; conversion_start |-> ##[0:2] compare_timer == 16'h0; endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("timer not cleared");
    property p_no_ovf; $rose(timer_overflow_flag) |->
        $past(compare_timer) == 16'hffff || $past(compare_timer, 2) == 16'hffff; endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("overflow without rollover");
    property p_sleep; $past(sleep) |-> $stable(period_timer) && $stable(compare_timer);
    endproperty
    a_sleep: assert property (p_sleep) else $error("timer moved in sleep");
    property p_wrap; $past(period_timer) == period_limit && $changed(period_timer)
        |-> period_timer == 8'h0; endproperty
    a_wrap: assert property (p_wrap) else $error("period timer not wrapped");
    property p_load; m[3:2] == 2'h3 && $past(m[3:2]) == 2'h3
        && $changed(active_duty_high_byte) |-> period_timer == 8'h0; endproperty
    a_load: assert property (p_load) else $error("duty loaded mid period");
    c_start: cover property (conversion_start);
    c_pwm_high: cover property (m[3:2] == 2'h3 && unit_output_pin);
    c_flag_clear: cover property ($fell(unit_irq_flag));
endmodule // compare_and_pwm_unit_assertions
`default_nettype wire

//--- testbench/compare_and_pwm_unit_test.sv
// self-checking bench for the compare and pwm unit
`timescale 1ns/1ns
`default_nettype none
module compare_and_pwm_unit_test;
    logic ref_clk, nrst, sleep, prun, crun, conv_en, dir, port_d, iclr, pclr;
    logic [3:0] mode;
    logic [1:0] dlo, ps;
    logic [7:0] lo, hi, limit;
    wire pin, oe, irq, ovf, pflag, cstart, pad;
    wire [7:0] adh, ptmr, starts;
    wire [15:0] ctmr;
    int error_cnt = 0;
    int comparisons = 0;
    compare_and_pwm_unit uut (.ref_clk, .nrst, .mode_select_field(mode),
        .duty_low_bits(dlo), .duty_or_compare_low_byte(lo), .compare_high_byte(hi),
        .period_limit(limit), .period_timer_prescale(ps), .period_timer_run(prun),
        .compare_timer_run(crun), .compare_timer_ext_clk(1'b0),
        .compare_timer_ext_mode(1'b0), .converter_enabled(conv_en), .sleep,
        .pin_direction_bit(dir), .port_data_latch(port_d), .irq_flag_clear(iclr),
        .overflow_flag_clear(1'b0), .period_flag_clear(pclr), .unit_output_pin(pin),
        .unit_output_pin_oe(oe), .unit_irq_flag(irq), .timer_overflow_flag(ovf),
        .period_timer_match_flag(pflag), .conversion_start(cstart),
        .active_duty_high_byte(adh), .period_timer(ptmr), .compare_timer(ctmr));
    pin_load_model far (.ref_clk, .pin, .pin_oe(oe), .start(cstart), .pad, .starts);
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ---
    // helpers
    // ---
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic set_cmp(input logic [3:0] md, input logic [15:0] v);
        mode <= md;
        {hi, lo} <= v;
        cyc(1);
    endtask
    task automatic wait_irq;
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 600) begin cyc(1); i++; end
        chk(irq, 1);
        iclr <= 1;
        cyc(1);
        iclr <= 0;
        cyc(1);
        chk(irq, 0);
    endtask
    // settle two windows, then count pad highs over one window
    task automatic pwm_run(input logic [1:0] p, input logic [9:0] d, input int w,
        input logic [15:0] e);
        int i;
        logic [15:0] n;
        ps <= p;
        {lo, dlo} <= d;
        cyc(2 * w);
        n = 0;
        for (i = 0; i < w; i++) begin cyc(1); n = n + {15'h0, pad}; end
        chk(n, e);
    endtask
    // ---
    // tests
    // ---
    task automatic test_compare;
        dir <= 0;
        crun <= 1;
        set_cmp(4'h8, 16'h0040); wait_irq; chk(pin, 1);
        set_cmp(4'h9, 16'h0080); wait_irq; chk(pin, 0);
        set_cmp(4'h8, 16'h00c0); wait_irq; chk(pin, 1);
        mode <= 4'h0; cyc(3); chk(pin, 0);
        port_d <= 1; cyc(3); chk(pin, 1);
        set_cmp(4'h8, 16'h0140); cyc(3); chk(pin, 0);
        set_cmp(4'ha, 16'h01c0); wait_irq; chk(pin, 1);
        $display("compare test done");
    endtask
    task automatic test_trigger;
        int i;
        logic [7:0] n0;
        logic [15:0] mx;
        conv_en <= 1;
        set_cmp(4'hb, 16'h0200);
        wait_irq;
        n0 = starts;
        mx = 0;
        for (i = 0; i < 1100; i++) begin cyc(1); if (ctmr > mx) mx = ctmr; end
        chk(mx, 16'h0200);
        chk({8'h0, starts - n0}, 16'h2);
        chk(ovf, 0);
        $display("trigger test done");
    endtask
    task automatic test_pwm;
        int i;
        logic [8:0] s;
        mode <= 4'hc;
        dir <= 1;
        prun <= 1;
        i = 0;
        while (pflag !== 1'b1 && i < 50) begin cyc(1); i++; end
        chk(pflag, 1);
        pclr <= 1; dir <= 0; cyc(1); pclr <= 0;
        pwm_run(2'h0, 10'h006, 16, 12);
        chk(adh, 8'h01);
        pwm_run(2'h1, 10'h006, 64, 48);
        pwm_run(2'h2, 10'h006, 256, 192);
        pwm_run(2'h0, 10'h000, 16, 0);
        pwm_run(2'h0, 10'h3ff, 16, 16);
        sleep <= 1; cyc(2); s = {pad, ptmr}; cyc(20);
        chk({pad, ptmr}, s);
        sleep <= 0; cyc(2);
        $display("pwm test done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {sleep, prun, crun, conv_en, port_d, iclr, pclr, nrst} = 8'h0;
        dir = 1; mode = 0; dlo = 0; ps = 0; lo = 0; hi = 0; limit = 8'h01;
        cyc(6);
        nrst <= 1;
        cyc(2);
        chk({pin, oe, irq, ovf, pflag, cstart}, 0);
        chk({adh, ptmr}, 0); chk(ctmr, 0);
        test_compare;
        test_trigger;
        test_pwm;
        give_verdict;
    end
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict;
    end
endmodule // compare_and_pwm_unit_test
bind compare_and_pwm_unit compare_and_pwm_unit_assertions chk_i (.ref_clk, .nrst,
    .mode_select_field, .duty_or_compare_low_byte, .compare_high_byte, .sleep,
    .irq_flag_clear, .unit_output_pin, .unit_irq_flag, .timer_overflow_flag,
    .conversion_start, .active_duty_high_byte, .period_limit, .period_timer,
    .compare_timer);
`default_nettype wire

//--- testbench/pin_load_model.sv
// far side: pin load with pull-down and converter start counter
`timescale 1ns/1ns
`default_nettype none
module pin_load_model (
    input wire logic ref_clk,
    input wire logic pin,
    input wire logic pin_oe,
    input wire logic start,
    output wire logic pad,
    output var logic [7:0] starts
);
    // pull-down holds the pad low while nobody drives it
    assign pad = pin_oe ? pin : 1'b0;
    initial starts = 8'h0;
    always @(posedge ref_clk) begin
        if (start === 1'b1) begin
            starts <= starts + 8'h1;
        end
    end
endmodule // pin_load_model
`default_nettype wire
